// ==== bench/sts_config_regs_properties.sv ====
/*
 Port checker for the supervisor timing and configuration bank.
 Assumes it is bound to sts_config_regs and sees only its ports.
*/
`timescale 1ns/10ps
module sts_cfg_checker (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Watched ports
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire otp_programmed_i,
  input wire [63:0] otp_image_i,
  input wire shutdown_active_i,
  input wire fourth_monitor_under_i,
  input wire watchdog_input_float_i,
  input wire other_reset_cause_i,
  input wire [2:0] reset_hold_time_o,
  input wire reset_request_o,
  input wire reset_pin_o
);
  // ==========================================================
  // Helper: fuse inputs and reset quiet for two edges
  reg live_q;
  reg prog_q;
  reg [63:0] img_q;
  reg calm_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_q <= 1'b0;
      prog_q <= 1'b0;
      img_q <= 64'h0;
      calm_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      prog_q <= otp_programmed_i;
      img_q <= otp_image_i;
      calm_q <= live_q && img_q == otp_image_i &&
        prog_q == otp_programmed_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Properties
  other_req_a: assert property (other_reset_cause_i |=> reset_request_o)
    else $error("request missing after reset cause");
  idle_req_a: assert property (!(shutdown_active_i |
    fourth_monitor_under_i | watchdog_input_float_i |
    other_reset_cause_i) |=> !reset_request_o)
    else $error("request without any cause");
  reset_val_a: assert property ($fell(rst_i) |-> reset_pin_o &&
    !reset_request_o && !sda_oe_o && reset_hold_time_o == 3'h0)
    else $error("wrong value after reset");
  sda_zero_a: assert property (sda_o == 1'b0)
    else $error("data value not zero");
  ack_rise_a: assert property ($rose(sda_oe_o) |-> !$past(scl_i))
    else $error("data pulled while clock high");
  oe_steady_a: assert property (scl_i && $past(scl_i) |->
    $stable(sda_oe_o)) else $error("data moved while clock high");
  code_chg_a: assert property ($changed(reset_hold_time_o) &&
    calm_q |-> !scl_i) else $error("code changed without a write");
  pol_chg_a: assert property ($changed(reset_pin_o ^
    reset_request_o) && calm_q |-> !scl_i)
    else $error("polarity changed without a write");
endmodule // sts_cfg_checker

bind sts_config_regs sts_cfg_checker chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .otp_programmed_i(otp_programmed_i), .otp_image_i(otp_image_i),
  .shutdown_active_i(shutdown_active_i),
  .fourth_monitor_under_i(fourth_monitor_under_i),
  .watchdog_input_float_i(watchdog_input_float_i),
  .other_reset_cause_i(other_reset_cause_i),
  .reset_hold_time_o(reset_hold_time_o),
  .reset_request_o(reset_request_o), .reset_pin_o(reset_pin_o));

// ==== bench/sts_host_model.sv ====
/*
 Host processor on the serial bus: START, STOP, bytes, register access.
 Assumes a pull-up on the data wire, resolved by the bench.
*/
`timescale 1ns/10ps
`include "sts_defs.vh"
module sts_host_model (
  // Clock
  input wire clk_i,
  // Serial pins
  input wire sda_i,
  output reg scl_o = 1'b1,
  output reg sda_oe_o = 1'b0
);
  // Every phase lasts several clocks so the slave's sampler sees it
  task bit_x(input b, output r);
    begin
      repeat (2) @(posedge clk_i);
      #5 sda_oe_o = ~b;
      repeat (2) @(posedge clk_i);
      #5 scl_o = 1'b1;
      repeat (3) @(posedge clk_i);
      r = sda_i;
      @(posedge clk_i);
      #5 scl_o = 1'b0;
    end
  endtask
  task start;
    begin
      @(posedge clk_i);
      #5 sda_oe_o = 1'b0;
      repeat (2) @(posedge clk_i);
      #5 scl_o = 1'b1;
      repeat (3) @(posedge clk_i);
      #5 sda_oe_o = 1'b1;
      repeat (3) @(posedge clk_i);
      #5 scl_o = 1'b0;
    end
  endtask
  task stop;
    begin
      repeat (2) @(posedge clk_i);
      #5 sda_oe_o = 1'b1;
      repeat (2) @(posedge clk_i);
      #5 scl_o = 1'b1;
      repeat (3) @(posedge clk_i);
      #5 sda_oe_o = 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task xfer(input [7:0] d, input m, output [7:0] r, output a);
    integer i;
    reg t;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(d[i], t);
        r[i] = t;
      end
      bit_x(m, a);
    end
  endtask
  task wr(input [7:0] p, input [7:0] v, output ok);
    reg [7:0] r;
    reg a0, a1, a2;
    begin
      start;
      xfer({`STS_DEV_ADDR, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      xfer(v, 1'b1, r, a2);
      stop;
      ok = ~(a0 | a1 | a2);
    end
  endtask
  task rd(input [7:0] p, output [7:0] v, output ok);
    reg [7:0] r;
    reg a0, a1, a2, a3;
    begin
      start;
      xfer({`STS_DEV_ADDR, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      start;
      xfer({`STS_DEV_ADDR, 1'b1}, 1'b1, r, a2);
      xfer(8'hff, 1'b1, v, a3); // Last byte is not acknowledged
      stop;
      ok = ~(a0 | a1 | a2);
    end
  endtask
endmodule // sts_host_model

// ==== bench/tb_top.sv ====
/*
 Self-checking bench for the register bank, driven by the host model.
 Assumes a 20 MHz clock and a pull-up on the data wire.
*/
`timescale 1ns/10ps
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg otp_p = 1'b0;
  reg [63:0] otp_img = 64'h0;
  reg [3:0] cause = 4'h0; // Shutdown, fourth, float, other
  wire scl, host_oe, dut_oe, sda, rail, adv, req, pin;
  wire [2:0] c0, c1, c2, c3, c4;
  integer failures = 0;
  integer tests_run = 0;
  reg [7:0] v;
  reg [7:0] k;
  reg ok;
  assign sda = ~(host_oe | dut_oe);
  initial forever #25 clk_i = ~clk_i;
  sts_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(host_oe));
  sts_config_regs dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(dut_oe), .otp_programmed_i(otp_p),
    .otp_image_i(otp_img), .shutdown_active_i(cause[3]),
    .fourth_monitor_under_i(cause[2]), .watchdog_input_float_i(cause[1]),
    .other_reset_cause_i(cause[0]),
    .primary_fault_shutdown_delay_time_o(c0),
    .turn_on_shutdown_hold_time_o(c1), .turn_off_shutdown_delay_time_o(c2),
    .reset_hold_time_o(c3), .watchdog_timeout_time_o(c4),
    .shutdown_rail_regulator_o(rail), .watchdog_advanced_o(adv),
    .reset_request_o(req), .reset_pin_o(pin));
  task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task w(input [7:0] p, input [7:0] d);
    begin
      host.wr(p, d, ok);
      chk("ack", 16'h1, {15'h0, ok});
    end
  endtask
  task r(input [7:0] p, input [7:0] e);
    begin
      host.rd(p, v, ok);
      chk("ack", 16'h1, {15'h0, ok});
      chk("read", {8'h0, e}, {8'h0, v});
    end
  endtask
  task rc(input [7:0] cf, input [3:0] cs, input [1:0] e);
    begin
      w(8'h0d, cf);
      @(posedge clk_i);
      #5 cause = cs;
      repeat (3) @(posedge clk_i);
      chk("reset", {14'h0, e}, {14'h0, req, pin});
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task test_defaults;
    begin
      for (k = 8'h08; k < 8'h10; k = k + 8'h01) r(k, 8'h00);
      chk("codes", 16'h0, {1'b0, c0, c1, c2, c3, c4});
      chk("pin", 16'h1, {15'h0, pin});
      chk("rail", 16'h0, {14'h0, rail, adv});
      $display("test_defaults done");
    end
  endtask
  task test_timing;
    begin
      for (k = 8'h08; k < 8'h0d; k = k + 8'h01) begin
        w(k, 8'hff);
        r(k, 8'h07);
        w(k, 8'h0d - k);
      end
      chk("c0", 16'h5, {13'h0, c0});
      chk("c1", 16'h4, {13'h0, c1});
      chk("c2", 16'h3, {13'h0, c2});
      chk("c3", 16'h2, {13'h0, c3});
      chk("c4", 16'h1, {13'h0, c4});
      $display("test_timing done");
    end
  endtask
  task test_rail;
    begin
      w(8'h0e, 8'hff);
      r(8'h0e, 8'h08);
      w(8'h0f, 8'hff);
      r(8'h0f, 8'h08);
      chk("rail", 16'h3, {14'h0, rail, adv});
      r(8'h07, 8'h00);
      w(8'h20, 8'h55);
      r(8'h20, 8'h00);
      $display("test_rail done");
    end
  endtask
  task test_reset_cfg;
    begin
      rc(8'h00, 4'h8, 2'b10);
      rc(8'h01, 4'h8, 2'b01);
      rc(8'h02, 4'h8, 2'b11);
      rc(8'h02, 4'h0, 2'b00);
      rc(8'h00, 4'h4, 2'b10);
      rc(8'h04, 4'h4, 2'b01);
      rc(8'h00, 4'h2, 2'b01);
      rc(8'h08, 4'h2, 2'b10);
      rc(8'hff, 4'h1, 2'b11);
      r(8'h0d, 8'h0f);
      rc(8'h00, 4'h0, 2'b01);
      $display("test_reset_cfg done");
    end
  endtask
  task test_override;
    begin
      @(posedge clk_i);
      #5 otp_img = 64'h0000_0000_0300_0000;
      otp_p = 1'b1;
      repeat (3) @(posedge clk_i);
      chk("hold", 16'h3, {13'h0, c3});
      w(8'h0b, 8'h06);
      chk("hold", 16'h3, {13'h0, c3});
      w(8'h16, 8'hff);
      r(8'h16, 8'h08);
      chk("hold", 16'h6, {13'h0, c3});
      w(8'h16, 8'h00);
      r(8'h0b, 8'h03);
      $display("test_override done");
    end
  endtask
  task test_mid_reset;
    begin
      @(posedge clk_i);
      #5 otp_p = 1'b0;
      cause = 4'h0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #5 rst_i = 1'b0;
      r(8'h0b, 8'h00);
      r(8'h16, 8'h00);
      chk("codes", 16'h0, {1'b0, c0, c1, c2, c3, c4});
      chk("pin", 16'h1, {15'h0, pin});
      $display("test_mid_reset done");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    #5 rst_i = 1'b0;
    test_defaults;
    test_timing;
    test_rail;
    test_reset_cfg;
    test_override;
    test_mid_reset;
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    failures = failures + 1;
    $display("[FAIL] run end expected done seen limit");
    stop_test;
  end
endmodule // tb_top

// ==== design/sts_config_regs.v ====
/*
 Timing and configuration register bank of the voltage supervisor, at
 offsets 0x08 to 0x0f, plus the override bit of 0x16, reached over the
 I2C-compatible serial pins. Holds the written values, chooses between
 them and the permanent (one-time programmed) image, and applies the
 reset configuration to the reset output.
 Assumes the fuse image, the monitor comparators and the timers sit
 outside; the timers take the selected codes from this block.
*/
// How it works
// - Bits 2:0 at 0x08 pick the primary monitor fault shutdown delay, code 0 being 1200 ms.
// - Bits 2:0 at 0x09 pick the shutdown hold after the second monitor turns on, code 0 being 10 ms.
// - Bits 2:0 at 0x0a pick the shutdown delay after the second monitor turns off, code 0 being 100 ms.
// - Bits 2:0 at 0x0b pick how long reset stays asserted after its cause clears, code 0 being 200 ms.
// - Bits 2:0 at 0x0c pick the watchdog timeout, code 0 being 1500 ms.
// - Bit 0 at 0x0d clear makes shutdown also assert reset, set stops shutdown alone from doing so.
// - Bit 1 at 0x0d sets reset polarity, 0 active low and 1 active high.
// - Bit 2 at 0x0d clear lets the fourth monitor under threshold cause reset, set blocks it.
// - Bit 3 at 0x0d set lets a floating watchdog input cause reset, clear does not.
// - Bit 3 at 0x0e picks the shutdown rail, 0 the primary monitor input and 1 the regulator rail.
// - The host writes and reads these registers over the serial interface.
// - With bit 3 at 0x16 set, written values override the permanent settings.
`timescale 1ns/10ps
`include "sts_defs.vh"

module sts_config_regs (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Serial pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // Permanent settings, byte n for offset 0x08 + n
  input wire otp_programmed_i,
  input wire [63:0] otp_image_i,
  // Reset causes
  input wire shutdown_active_i,
  input wire fourth_monitor_under_i,
  input wire watchdog_input_float_i,
  input wire other_reset_cause_i,
  // Selected timing codes
  output reg [2:0] primary_fault_shutdown_delay_time_o,
  output reg [2:0] turn_on_shutdown_hold_time_o,
  output reg [2:0] turn_off_shutdown_delay_time_o,
  output reg [2:0] reset_hold_time_o,
  output reg [2:0] watchdog_timeout_time_o,
  // Configuration and reset output
  output reg shutdown_rail_regulator_o,
  output reg watchdog_advanced_o,
  output reg reset_request_o,
  output reg reset_pin_o
);

  // ========================================================================
  // Storage
  reg [7:0] bank_q [0:7];
  reg override_q;
  wire [7:0] ptr_w;
  wire wr_stb_w;
  wire [7:0] wr_addr_w;
  wire [7:0] wr_data_w;
  reg [7:0] rd_data;
  wire [2:0] widx_w;
  wire use_otp_w;
  integer i;

  assign widx_w = wr_addr_w[2:0];
  // Without fuses the written bank is in force from power-up
  assign use_otp_w = otp_programmed_i & ~override_q;

  // Writable bits per bank slot
  // Slots 0 to 4 hold the three-bit timing codes
  function [7:0] bank_mask;
    input [2:0] idx;
    begin
      case (idx)
        3'h5: bank_mask = `STS_MASK_RST_CFG;
        3'h6: bank_mask = `STS_MASK_SD_RAIL;
        3'h7: bank_mask = `STS_MASK_WD_MODE;
        default: bank_mask = `STS_MASK_TIMING;
      endcase
    end
  endfunction

  // Value in force: fuse image unless overridden or never programmed
  function [7:0] eff_val;
    input [2:0] idx;
    input sel_otp;
    input [7:0] written;
    input [63:0] image;
    begin
      if (sel_otp) begin
        eff_val = image[idx*8 +: 8] & bank_mask(idx);
      end else begin
        eff_val = written;
      end
    end
  endfunction

  // ========================================================================
  // Serial interface
  sts_serial_slave u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .ptr_o(ptr_w),
    .rd_data_i(rd_data),
    .wr_stb_o(wr_stb_w),
    .wr_addr_o(wr_addr_w),
    .wr_data_o(wr_data_w)
  );

  // ========================================================================
  // Register writes
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        bank_q[i] <= `STS_REG_RESET;
      end
      override_q <= 1'b0;
    end else if (wr_stb_w) begin
      // Writes land even under fuse selection, so a later override
      // takes effect at once
      if (wr_addr_w >= `STS_BANK_BASE && wr_addr_w <= `STS_BANK_LAST) begin
        bank_q[widx_w] <= wr_data_w & bank_mask(widx_w);
      end else if (wr_addr_w == `STS_OFF_SPECIAL1) begin
        // Only the override bit of 0x16 is kept here
        override_q <= wr_data_w[`STS_SPECIAL1_OVERRIDE];
      end
    end
  end

  // ========================================================================
  // Values in force
  wire [7:0] v_pri_w;
  wire [7:0] v_on_w;
  wire [7:0] v_off_w;
  wire [7:0] v_rh_w;
  wire [7:0] v_wd_w;
  wire [7:0] v_cfg_w;
  wire [7:0] v_rail_w;
  wire [7:0] v_mode_w;
  wire cause_w;

  assign v_pri_w = eff_val(3'h0, use_otp_w, bank_q[0], otp_image_i);
  assign v_on_w = eff_val(3'h1, use_otp_w, bank_q[1], otp_image_i);
  assign v_off_w = eff_val(3'h2, use_otp_w, bank_q[2], otp_image_i);
  assign v_rh_w = eff_val(3'h3, use_otp_w, bank_q[3], otp_image_i);
  assign v_wd_w = eff_val(3'h4, use_otp_w, bank_q[4], otp_image_i);
  assign v_cfg_w = eff_val(3'h5, use_otp_w, bank_q[5], otp_image_i);
  assign v_rail_w = eff_val(3'h6, use_otp_w, bank_q[6], otp_image_i);
  assign v_mode_w = eff_val(3'h7, use_otp_w, bank_q[7], otp_image_i);

  // ========================================================================
  // Register reads show the value in force, so the host sees what the
  // timers really use; unmapped offsets answer 0x00
  always @* begin
    rd_data = 8'h00;
    case (ptr_w)
      `STS_OFF_PRI_SD_DELAY: rd_data = v_pri_w;
      `STS_OFF_ON_SD_HOLD: rd_data = v_on_w;
      `STS_OFF_OFF_SD_DELAY: rd_data = v_off_w;
      `STS_OFF_RST_HOLD: rd_data = v_rh_w;
      `STS_OFF_WD_TIMEOUT: rd_data = v_wd_w;
      `STS_OFF_RST_CFG: rd_data = v_cfg_w;
      `STS_OFF_SD_RAIL: rd_data = v_rail_w;
      `STS_OFF_WD_MODE: rd_data = v_mode_w;
      `STS_OFF_SPECIAL1: rd_data = {4'h0, override_q, 3'h0};
      default: rd_data = 8'h00;
    endcase
  end

  // Causes are gated here; hold time stretching belongs to the timer
  assign cause_w =
    (shutdown_active_i & ~v_cfg_w[`STS_RST_CFG_SD_NORST]) |
    (fourth_monitor_under_i & ~v_cfg_w[`STS_RST_CFG_V4_MASK]) |
    (watchdog_input_float_i & v_cfg_w[`STS_RST_CFG_WD_FLOAT]) |
    other_reset_cause_i;

  // ========================================================================
  // Registered outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      primary_fault_shutdown_delay_time_o <= 3'h0;
      turn_on_shutdown_hold_time_o <= 3'h0;
      turn_off_shutdown_delay_time_o <= 3'h0;
      reset_hold_time_o <= 3'h0;
      watchdog_timeout_time_o <= 3'h0;
      shutdown_rail_regulator_o <= 1'b0;
      watchdog_advanced_o <= 1'b0;
    end else begin
      primary_fault_shutdown_delay_time_o <= v_pri_w[2:0];
      turn_on_shutdown_hold_time_o <= v_on_w[2:0];
      turn_off_shutdown_delay_time_o <= v_off_w[2:0];
      reset_hold_time_o <= v_rh_w[2:0];
      watchdog_timeout_time_o <= v_wd_w[2:0];
      shutdown_rail_regulator_o <= v_rail_w[`STS_SD_RAIL_REG];
      watchdog_advanced_o <= v_mode_w[`STS_WD_MODE_ADV];
    end
  end

  // ========================================================================
  // Reset output
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_request_o <= 1'b0;
      // Reset default polarity is active low, so idle is high
      reset_pin_o <= 1'b1;
    end else begin
      // Request stays active high whatever the pin polarity
      reset_request_o <= cause_w;
      reset_pin_o <= v_cfg_w[`STS_RST_CFG_POL_HIGH] ? cause_w
                                                     : ~cause_w;
    end
  end

endmodule // sts_config_regs

// ==== design/sts_defs.vh ====
/*
 Constants for the supervisor timing and configuration register bank:
 register offsets, writable bit masks, reset values, field positions,
 serial bus framing and the times that timing code 0 stands for.
 Assumes it is included by bare name from the design files.
*/
`ifndef STS_DEFS_VH
`define STS_DEFS_VH

// ==========================================================================
// Register offsets
`define STS_OFF_PRI_SD_DELAY 8'h08
`define STS_OFF_ON_SD_HOLD 8'h09
`define STS_OFF_OFF_SD_DELAY 8'h0a
`define STS_OFF_RST_HOLD 8'h0b
`define STS_OFF_WD_TIMEOUT 8'h0c
`define STS_OFF_RST_CFG 8'h0d
`define STS_OFF_SD_RAIL 8'h0e
`define STS_OFF_WD_MODE 8'h0f
`define STS_OFF_SPECIAL1 8'h16
`define STS_BANK_BASE 8'h08
`define STS_BANK_LAST 8'h0f

// ==========================================================================
// Writable bits of each register and the register reset value; every other bit is reserved
`define STS_MASK_TIMING 8'h07
`define STS_MASK_RST_CFG 8'h0f
`define STS_MASK_SD_RAIL 8'h08
`define STS_MASK_WD_MODE 8'h08
`define STS_MASK_SPECIAL1 8'h08
`define STS_REG_RESET 8'h00

// ==========================================================================
// Field positions
`define STS_RST_CFG_SD_NORST 0
`define STS_RST_CFG_POL_HIGH 1
`define STS_RST_CFG_V4_MASK 2
`define STS_RST_CFG_WD_FLOAT 3
`define STS_SD_RAIL_REG 3
`define STS_WD_MODE_ADV 3
`define STS_SPECIAL1_OVERRIDE 3

// ==========================================================================
// Serial bus framing
`define STS_DEV_ADDR 7'h2a
`define STS_BITS_PER_BYTE 4'h8

// ==========================================================================
// Time selected by code 0 of each timing field, in ms, and the clock rate in kHz
`define STS_PRI_SD_DELAY_MS 1200
`define STS_ON_SD_HOLD_MS 10
`define STS_OFF_SD_DELAY_MS 100
`define STS_RST_HOLD_MS 200
`define STS_WD_TIMEOUT_MS 1500
`define STS_CLK_KHZ 20000

`endif

// ==== design/sts_serial_slave.v ====
/*
 Byte-level slave of the I2C-compatible serial interface. Decodes START
 and STOP, matches the device address, keeps the register pointer with
 auto-increment and hands each written byte out as a one-cycle strobe.
 Assumes scl_i and sda_i are already synchronous to clk_i and that the
 bus wire is resolved outside from sda_oe_o (open drain, low only).
*/
`timescale 1ns/10ps
`include "sts_defs.vh"

module sts_serial_slave (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Serial pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // Register side
  output reg [7:0] ptr_o,
  input wire [7:0] rd_data_i,
  output reg wr_stb_o,
  output reg [7:0] wr_addr_o,
  output reg [7:0] wr_data_o
);

  // ========================================================================
  // States
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ACKA = 9'h004;
  localparam [8:0] S_PTR = 9'h008;
  localparam [8:0] S_ACKP = 9'h010;
  localparam [8:0] S_WDAT = 9'h020;
  localparam [8:0] S_ACKW = 9'h040;
  localparam [8:0] S_RDAT = 9'h080;
  localparam [8:0] S_RACK = 9'h100;

  reg [8:0] st_q;
  reg scl_q;
  reg sda_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg rnw_q;
  reg oe_q;
  wire start_w;
  wire stop_w;
  wire rise_w;
  wire fall_w;

  assign start_w = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_w = scl_i & scl_q & ~sda_q & sda_i;
  assign rise_w = scl_i & ~scl_q;
  assign fall_w = ~scl_i & scl_q;
  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;

  // ========================================================================
  // Byte engine
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      rnw_q <= 1'b0;
      oe_q <= 1'b0;
      ptr_o <= 8'h00;
      wr_stb_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_stb_o <= 1'b0;
      if (stop_w) begin
        st_q <= S_IDLE;
        oe_q <= 1'b0;
      end else if (start_w) begin
        // Repeated START keeps the pointer for a following read
        st_q <= S_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: begin
            oe_q <= 1'b0;
          end
          S_ADDR, S_PTR, S_WDAT: begin
            if (rise_w) begin
              sh_q <= {sh_q[6:0], sda_i};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall_w && cnt_q == `STS_BITS_PER_BYTE) begin
              cnt_q <= 4'h0;
              oe_q <= 1'b1;
              if (st_q == S_ADDR) begin
                if (sh_q[7:1] == `STS_DEV_ADDR) begin
                  rnw_q <= sh_q[0];
                  st_q <= S_ACKA;
                end else begin
                  // Not addressed: stay off the bus until the next START
                  oe_q <= 1'b0;
                  st_q <= S_IDLE;
                end
              end else if (st_q == S_PTR) begin
                ptr_o <= sh_q;
                st_q <= S_ACKP;
              end else begin
                wr_stb_o <= 1'b1;
                wr_addr_o <= ptr_o;
                wr_data_o <= sh_q;
                ptr_o <= ptr_o + 8'h01;
                st_q <= S_ACKW;
              end
            end
          end
          S_ACKA: begin
            if (fall_w) begin
              if (rnw_q) begin
                sh_q <= rd_data_i;
                oe_q <= ~rd_data_i[7];
                st_q <= S_RDAT;
              end else begin
                oe_q <= 1'b0;
                st_q <= S_PTR;
              end
            end
          end
          S_ACKP, S_ACKW: begin
            if (fall_w) begin
              oe_q <= 1'b0;
              st_q <= S_WDAT;
            end
          end
          S_RDAT: begin
            if (fall_w) begin
              if (cnt_q == `STS_BITS_PER_BYTE - 4'h1) begin
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
                ptr_o <= ptr_o + 8'h01;
                st_q <= S_RACK;
              end else begin
                cnt_q <= cnt_q + 4'h1;
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= ~sh_q[6];
              end
            end
          end
          S_RACK: begin
            if (rise_w && sda_i) begin
              // Master NACK ends the read
              st_q <= S_IDLE;
            end else if (fall_w) begin
              sh_q <= rd_data_i;
              oe_q <= ~rd_data_i[7];
              st_q <= S_RDAT;
            end
          end
          default: begin
            st_q <= S_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // sts_serial_slave
